//--- core/rmpsl_defs.svh
// Register offsets, field positions and reset values of the pin remap block
`ifndef RMPSL_DEFS_SVH
`define RMPSL_DEFS_SVH

`define RMPSL_SYSCFG_ADDR      12'h000
`define RMPSL_UNLOCK_ADDR      12'h004
`define RMPSL_STATUS_ADDR      12'h008
`define RMPSL_OUTSEL_BASE      12'h100
`define RMPSL_INMAP_BASE       12'h200
`define RMPSL_LOCK_BIT         13
`define RMPSL_ONEWAY_BIT       29
`define RMPSL_SEL_W            4
`define RMPSL_SEL_NULL         4'h0
`define RMPSL_SYSCFG_RST       32'h0000_0000
`define RMPSL_CFGWORD3_DEFAULT 32'hFFFF_FFFF
`define RMPSL_KEY1             32'hAA99_6655
`define RMPSL_KEY2             32'h5566_99AA

`endif

//--- core/rmpsl_pkg.sv
// Types shared by the pin remap block
package rmpsl_pkg;
  typedef enum logic [1:0] {UnlockIdle, UnlockKey1, UnlockOpen} rmpsl_unlock_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rmpsl_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rmpsl_apb_rsp_s;
endpackage : rmpsl_pkg

//--- core/rmpsl_remap.sv
// Output pin remap select registers with write lock, unlock sequence and one-way option
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`include "rmpsl_defs.svh"

// How it works
// - Every remappable pin has its own select register choosing its peripheral.
// - Selector fields are four bits; the code names the peripheral routed to pin.
// - Code zero is the reset value and drives no peripheral onto the pin.
// - Locked writes to select or input map registers finish cleanly but change nothing.
// - Lock bit is bit 13 of system config; one blocks writes, zero allows.
// - Lock bit changes only after the unlock key sequence; otherwise ignored.
// - With single-session option set, lock cannot be cleared once set.
// - Under that option, set lock refuses unlock and select registers stay unwritable.
// - Under that option only device reset clears the lock again.
// - Unprogrammed configuration word reads single-session option as set.
module rmpsl_remap
  import rmpsl_pkg::*;
#(
  parameter int          NUM_PINS   = 8,
  parameter int          NUM_PERIPH = 6,
  parameter int          NUM_INMAP  = 4,
  parameter logic [31:0] CFG_WORD3  = `RMPSL_CFGWORD3_DEFAULT
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire rmpsl_apb_req_s        apbReq,
  output rmpsl_apb_rsp_s             apbRsp,
  input  wire logic [NUM_PERIPH-1:0] periphOut,
  input  wire logic [NUM_PERIPH-1:0] periphOutEn,
  output logic      [NUM_PINS-1:0]   pinOut,
  output logic      [NUM_PINS-1:0]   pinOutEn,
  output logic      [NUM_INMAP*4-1:0] inMapSel,
  output logic                       mapWriteLock
);

  typedef struct packed {
    logic [NUM_PINS-1:0][`RMPSL_SEL_W-1:0]  outSel;
    logic [NUM_INMAP-1:0][`RMPSL_SEL_W-1:0] inMap;
    logic                                   lock;
    logic                                   lockedOnce;
    rmpsl_unlock_e                          unlock;
    logic [NUM_PINS-1:0]                    pinOut;
    logic [NUM_PINS-1:0]                    pinOutEn;
    logic [31:0]                            prdata;
  } rmpsl_state_s;

  rmpsl_state_s st;
  rmpsl_state_s next_st;

  logic        oneWay;
  logic        access;
  logic        wrAcc;
  logic        rdAcc;
  logic [11:0] addr;
  logic [31:0] wdata;

  // Option sampled from the configuration word
  assign oneWay = CFG_WORD3[`RMPSL_ONEWAY_BIT];
  assign access = apbReq.psel & apbReq.penable;
  assign wrAcc  = access & apbReq.pwrite;
  assign rdAcc  = access & ~apbReq.pwrite;
  assign addr   = apbReq.paddr;
  assign wdata  = apbReq.pwdata;

  // Zero wait state slave; no access is ever flagged as an error
  assign apbRsp.pready  = 1'b1;
  assign apbRsp.pslverr = 1'b0;
  assign apbRsp.prdata  = st.prdata;
  assign pinOut         = st.pinOut;
  assign pinOutEn       = st.pinOutEn;
  assign inMapSel       = st.inMap;
  assign mapWriteLock   = st.lock;

  // Next state: bus writes, unlock sequence, read data and pin mux
  always_comb begin
    logic [3:0] code;
    logic       lockWanted;
    code       = `RMPSL_SEL_NULL;
    lockWanted = 1'b0;
    next_st    = st;
    next_st.prdata = 32'h0000_0000;

    if (wrAcc) begin
      if (addr == `RMPSL_UNLOCK_ADDR) begin
        // Two keys back to back open one lock change; one-way blocks reopening
        if (oneWay && st.lockedOnce && st.lock) begin
          next_st.unlock = UnlockIdle;
        end else if (wdata == `RMPSL_KEY1) begin
          next_st.unlock = UnlockKey1;
        end else if (wdata == `RMPSL_KEY2 && st.unlock == UnlockKey1) begin
          next_st.unlock = UnlockOpen;
        end else begin
          next_st.unlock = UnlockIdle;
        end
      end else if (addr == `RMPSL_SYSCFG_ADDR) begin
        lockWanted = wdata[`RMPSL_LOCK_BIT];
        if (st.unlock == UnlockOpen) begin
          if (lockWanted) begin
            next_st.lock       = 1'b1;
            next_st.lockedOnce = 1'b1;
          end else if (!(oneWay && st.lockedOnce)) begin
            next_st.lock = 1'b0;
          end
          next_st.unlock = UnlockIdle;
        end
      end else if (addr >= `RMPSL_OUTSEL_BASE && addr < `RMPSL_INMAP_BASE) begin
        // Locked writes are acknowledged but dropped
        for (int i = 0; i < NUM_PINS; i++) begin
          if (!st.lock && addr == `RMPSL_OUTSEL_BASE + 12'(i * 4)) begin
            next_st.outSel[i] = wdata[`RMPSL_SEL_W-1:0];
          end
        end
      end else begin
        for (int i = 0; i < NUM_INMAP; i++) begin
          if (!st.lock && addr == `RMPSL_INMAP_BASE + 12'(i * 4)) begin
            next_st.inMap[i] = wdata[`RMPSL_SEL_W-1:0];
          end
        end
      end
    end

    // Read data registered so it stands through the access phase
    if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
      if (addr == `RMPSL_SYSCFG_ADDR) begin
        next_st.prdata[`RMPSL_LOCK_BIT] = st.lock;
      end else if (addr == `RMPSL_STATUS_ADDR) begin
        next_st.prdata[`RMPSL_ONEWAY_BIT] = oneWay;
        next_st.prdata[1:0] = st.unlock;
      end else begin
        for (int i = 0; i < NUM_PINS; i++) begin
          if (addr == `RMPSL_OUTSEL_BASE + 12'(i * 4)) begin
            next_st.prdata[`RMPSL_SEL_W-1:0] = st.outSel[i];
          end
        end
        for (int i = 0; i < NUM_INMAP; i++) begin
          if (addr == `RMPSL_INMAP_BASE + 12'(i * 4)) begin
            next_st.prdata[`RMPSL_SEL_W-1:0] = st.inMap[i];
          end
        end
      end
    end

    // Pin mux: code n selects peripheral n-1, zero or out of range is null
    for (int p = 0; p < NUM_PINS; p++) begin
      code = st.outSel[p];
      next_st.pinOut[p]   = 1'b0;
      next_st.pinOutEn[p] = 1'b0;
      for (int k = 0; k < NUM_PERIPH; k++) begin
        if (code == 4'(k + 1)) begin
          next_st.pinOut[p]   = periphOut[k];
          next_st.pinOutEn[p] = periphOutEn[k];
        end
      end
    end
  end

  // State register; reset disconnects every pin and clears the lock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : rmpsl_remap

//--- verification/rmpsl_remap_monitor.sv
// Port-level checks of the pin remap block
`timescale 1ns/1ns
`include "rmpsl_defs.svh"
module rmpsl_remap_monitor
  import rmpsl_pkg::*;
#(
  parameter int          NUM_PINS   = 8,
  parameter int          NUM_PERIPH = 6,
  parameter int          NUM_INMAP  = 4,
  parameter logic [31:0] CFG_WORD3  = `RMPSL_CFGWORD3_DEFAULT
) (
  input wire logic                   clk,
  input wire logic                   sys_rst,
  input wire rmpsl_apb_req_s         apbReq,
  input wire rmpsl_apb_rsp_s         apbRsp,
  input wire logic [NUM_PERIPH-1:0]  periphOut,
  input wire logic [NUM_PERIPH-1:0]  periphOutEn,
  input wire logic [NUM_PINS-1:0]    pinOut,
  input wire logic [NUM_PINS-1:0]    pinOutEn,
  input wire logic [NUM_INMAP*4-1:0] inMapSel,
  input wire logic                   mapWriteLock
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic wr;
  logic lockWr;
  // Accepted write, and one that asks for the lock
  assign wr = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign lockWr = wr && apbReq.paddr == `RMPSL_SYSCFG_ADDR && apbReq.pwdata[`RMPSL_LOCK_BIT];
  no_error_a: assert property (apbReq.psel |-> !apbRsp.pslverr) else $error("bus error");
  zero_wait_a: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("ready late");
  reset_lock_a: assert property (disable iff (1'b0) sys_rst |=> !mapWriteLock && !pinOutEn)
    else $error("reset state");
  locked_map_a: assert property (wr && mapWriteLock |=> $stable(inMapSel))
    else $error("locked write landed");
  lock_cause_a: assert property (!wr |=> $stable(mapWriteLock)) else $error("lock moved");
  lock_set_a: assert property ($rose(mapWriteLock) |-> $past(lockWr)) else $error("lock rose");
  one_way_a: assert property ($fell(mapWriteLock) |-> !CFG_WORD3[`RMPSL_ONEWAY_BIT])
    else $error("lock cleared");
  null_pin_a: assert property (!$past(|periphOutEn) |-> !pinOutEn) else $error("pin driven");
endmodule : rmpsl_remap_monitor

bind rmpsl_remap rmpsl_remap_monitor #(.NUM_PINS(NUM_PINS), .NUM_PERIPH(NUM_PERIPH),
  .NUM_INMAP(NUM_INMAP), .CFG_WORD3(CFG_WORD3)) rmpsl_remap_monitor_i (.clk(clk), .sys_rst(sys_rst),
  .apbReq(apbReq), .apbRsp(apbRsp), .periphOut(periphOut), .periphOutEn(periphOutEn),
  .pinOut(pinOut), .pinOutEn(pinOutEn), .inMapSel(inMapSel), .mapWriteLock(mapWriteLock));

//--- verification/tb_top.sv
// Self-checking bench of the pin remap block
`timescale 1ns/1ns
`include "rmpsl_defs.svh"
`define CHK(n,e,s) begin comparisons++; if ((s) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_top
  import rmpsl_pkg::*;
;
  logic           clk = 1'b0;
  logic           sys_rst = 1'b1;
  rmpsl_apb_req_s apbReq = '0;
  rmpsl_apb_rsp_s apbRsp;
  logic [5:0]     periphOut = 6'h04;
  logic [5:0]     periphOutEn = 6'h3F;
  logic [7:0]     pinOut, pinOutEn;
  logic           lock;
  logic [31:0]    rd;
  int             num_errors = 0, comparisons = 0, cycles = 0;
  always #5 clk = ~clk;
  rmpsl_remap rmpsl_remap_i (.clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
    .periphOut(periphOut), .periphOutEn(periphOutEn), .pinOut(pinOut), .pinOutEn(pinOutEn),
    .inMapSel(), .mapWriteLock(lock));
  // One APB transfer; an idle edge after it keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    apbReq <= '0;
    @(posedge clk);
  endtask : apb
  task automatic rst;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask : rst
  task automatic unlock;
    apb(1'b1, `RMPSL_UNLOCK_ADDR, `RMPSL_KEY1);
    apb(1'b1, `RMPSL_UNLOCK_ADDR, `RMPSL_KEY2);
  endtask : unlock
  task automatic t_map;
    apb(1'b0, `RMPSL_OUTSEL_BASE, 32'h0);
    `CHK("sel0", 32'h0, rd)
    `CHK("pinEn", 8'h00, pinOutEn)
    apb(1'b0, `RMPSL_STATUS_ADDR, 32'h0);
    `CHK("oneway", 1'b1, rd[29])
    apb(1'b1, `RMPSL_OUTSEL_BASE, 32'h3);
    apb(1'b1, `RMPSL_OUTSEL_BASE + 12'h004, 32'hF);
    apb(1'b1, `RMPSL_INMAP_BASE, 32'h5);
    apb(1'b0, `RMPSL_INMAP_BASE, 32'h0);
    `CHK("inmap", 32'h5, rd)
    `CHK("pins", 3'b011, {pinOutEn[1:0], pinOut[0]})
    apb(1'b0, 12'h040, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    periphOutEn <= 6'h00;
    repeat (2) @(posedge clk);
    `CHK("pinEnOff", 8'h00, pinOutEn)
    periphOutEn <= 6'h3F;
    $display("done map");
  endtask : t_map
  task automatic t_lock;
    apb(1'b1, `RMPSL_SYSCFG_ADDR, 32'h2000);
    `CHK("nokey", 1'b0, lock)
    unlock();
    apb(1'b1, `RMPSL_SYSCFG_ADDR, 32'h2000);
    `CHK("locked", 1'b1, lock)
    apb(1'b1, `RMPSL_OUTSEL_BASE, 32'h1);
    apb(1'b0, `RMPSL_OUTSEL_BASE, 32'h0);
    `CHK("kept", 32'h3, rd)
    unlock();
    apb(1'b1, `RMPSL_SYSCFG_ADDR, 32'h0);
    `CHK("oneway", 1'b1, lock)
    apb(1'b1, `RMPSL_INMAP_BASE, 32'h9);
    apb(1'b0, `RMPSL_INMAP_BASE, 32'h0);
    `CHK("inmapKept", 32'h5, rd)
    rst();
    `CHK("cleared", 1'b0, lock)
    $display("done lock");
  endtask : t_lock
  task automatic conclude;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Hang guard well above the run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    rst();
    t_map();
    t_lock();
    conclude();
  end
endmodule : tb_top
